// ===== src/spi_lp_consts.vh
`ifndef SPI_LP_CONSTS_VH
`define SPI_LP_CONSTS_VH
// register byte offsets
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4
`define OFS_MASK 4'h8
`define OFS_DATA 4'hc
// control register fields
`define CTL_ENABLE 0
`define CTL_MASTER 1
`define CTL_BIDIR 2
`define CTL_BIDIR_OE 3
`define CTL_STOP_IN_WAIT 4
`define CTL_MODF_EN 5
`define CTL_ECHO 6
`define CTL_RESET 8'h00
// status fields
`define ST_DONE 0
`define ST_MODF 1
// master clock half period is this many mclk cycles plus one
`define SCK_HALF 8'h04
`endif

// ===== src/spi_bidir_lowpower_ctrl.v
`timescale 1ns/100ps
`include "spi_lp_consts.vh"
module spi_bidir_lowpower_ctrl (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // low power requests
  input wire cpu_wait,
  input wire cpu_stop,
  // serial pins
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe,
  input wire ss_n_i,
  input wire mosi_i,
  output wire mosi_o,
  output wire mosi_oe,
  input wire miso_i,
  output wire miso_o,
  output wire miso_oe,
  // interrupt
  output wire irq
);

// ------------------------------------------------
// reset release
// ------------------------------------------------
reg rst_s1_q;
reg rst_s2_q; // synchronised reset, active low
always @(posedge mclk or negedge rst_n) begin
  if (!rst_n) begin
    rst_s1_q <= 1'b0;
    rst_s2_q <= 1'b0;
  end else begin
    rst_s1_q <= 1'b1;
    rst_s2_q <= rst_s1_q;
  end
end
wire rstn = rst_s2_q;
// every other process resets from this copy, so the
// release reaches all flops on the same mclk edge and
// no flop leaves reset one cycle before its neighbour
// reading state in mid-release.
// assertion of reset stays asynchronous: the whole
// block falls to its idle levels at once, output
// enables low, without waiting for a clock edge.
// a reset pulse shorter than one cycle still works.

// ------------------------------------------------
// input synchronisers
// ------------------------------------------------
// pins and the stop request come from outside mclk,
// so each passes two flops before logic reads it.
// the cost is two cycles of lag on every link edge,
// which is why the link clock must stay slow enough
// for several mclk cycles per half period.
// reset values match the idle levels of the pins.
wire [4:0] pin_raw = {sck_i, ss_n_i, mosi_i, miso_i, cpu_stop};
reg [4:0] pin_s1_q; // first stage, read only by second
reg [4:0] pin_s2_q; // synchronised copy
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    pin_s1_q <= 5'h08; // sck idle low, select high
    pin_s2_q <= 5'h08; // no false sck edge after reset
  end else begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
  end
end
wire sck_s = pin_s2_q[4];
wire ss_n_s = pin_s2_q[3];
wire mosi_s = pin_s2_q[2];
wire miso_s = pin_s2_q[1];
wire stop_s = pin_s2_q[0];
reg sck_prev_q; // for slave edge detect
always @(posedge mclk or negedge rstn) begin
  if (!rstn)
    sck_prev_q <= 1'b0;
  else
    sck_prev_q <= sck_s;
end
wire sck_rise = sck_s & ~sck_prev_q;

// ------------------------------------------------
// registers
// ------------------------------------------------
reg [7:0] ctrl_q; // control bits
reg [1:0] stat_q; // sticky events
reg [1:0] mask_q; // interrupt mask
reg [7:0] data_q; // serial data register, received byte
reg [7:0] tx_q; // byte to send next
reg tx_pend_q; // master start request
reg mode_master_q; // effective role, cleared by mode fault

// bus requests are taken when cyc and stb are high
// and no ack is out; ack follows one cycle later.
// read data is latched at the taken edge and stands
// until the next request.
// a write lands at the edge where the master sees
// ack high, so the master may rely on the register
// holding the new value from that edge on.
// only byte lane 0 carries register bits.
wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

// low power state of the block
wire wait_lp = cpu_wait & ctrl_q[`CTL_STOP_IN_WAIT];
wire low_pwr = wait_lp | stop_s;
reg low_pwr_q;
always @(posedge mclk or negedge rstn) begin
  if (!rstn)
    low_pwr_q <= 1'b0;
  else
    low_pwr_q <= low_pwr;
end
wire lp_enter = low_pwr & ~low_pwr_q;
wire lp_exit = ~low_pwr & low_pwr_q;

wire bidir = ctrl_q[`CTL_BIDIR];
wire is_master = mode_master_q;
wire modf_det = is_master & ctrl_q[`CTL_MODF_EN] & ~ss_n_s;

// ------------------------------------------------
// shift engine
// ------------------------------------------------
reg [7:0] sh_q; // shift register
reg [2:0] bit_q; // bits received
reg busy_q; // transfer in progress
reg [7:0] div_q; // master half period count
reg sck_gen_q; // generated clock
reg done_p; // byte finished (comb)
reg lp_busy_q; // transfer touched low power
reg held_q; // finished byte waiting for exit
reg [7:0] held_byte_q;
reg [7:0] echo_q; // last finished byte, not read by any logic
reg rx_smp_q; // master bit sampled on sck rise
// master timing: the incoming bit is caught on the
// rising half and only shifted in on the falling half,
// so the outgoing bit never moves at the edge where
// the far side samples it.
// slave timing: shift on the synchronised rising edge,
// the external master owns the clock and its phase.
// while halted the master holds div, bit and shift
// register, so a resumed byte continues bit-exact.
// master: one byte per data write; no queue of bytes.
// shared pin selects data source for input
wire rx_bit = bidir ? (is_master ? mosi_s : miso_s)
                    : (is_master ? miso_s : mosi_s);
// append one serial bit to a byte, msb first
function [7:0] shift_in(input [7:0] sh, input b);
  begin
    shift_in = {sh[6:0], b};
  end
endfunction
// byte as it stands once the last bit arrives
wire [7:0] next_byte = shift_in(sh_q, is_master ? rx_smp_q : rx_bit);
// master may not tick while halted
wire m_run = busy_q & is_master & ~low_pwr;
always @* begin
  done_p = 1'b0;
  if (is_master)
    done_p = m_run && div_q == 8'h00 && sck_gen_q && bit_q == 3'h7;
  else
    done_p = ~ss_n_s && sck_rise && bit_q == 3'h7;
end

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    sh_q <= 8'h00;
    bit_q <= 3'h0;
    busy_q <= 1'b0;
    div_q <= 8'h00;
    sck_gen_q <= 1'b0;
    rx_smp_q <= 1'b0;
  end else if (!ctrl_q[`CTL_ENABLE] || modf_det) begin
    busy_q <= 1'b0;
    bit_q <= 3'h0;
    sck_gen_q <= 1'b0;
  end else if (is_master) begin
    if (!busy_q && tx_pend_q && !low_pwr) begin
      sh_q <= tx_q;
      busy_q <= 1'b1;
      div_q <= `SCK_HALF;
    end else if (m_run) begin // frozen otherwise
      if (div_q != 8'h00) begin
        div_q <= div_q - 8'h01;
      end else begin
        div_q <= `SCK_HALF;
        sck_gen_q <= ~sck_gen_q;
        if (!sck_gen_q) begin
          // rising half: capture only
          rx_smp_q <= rx_bit;
        end else begin
          // falling half: shift, next bit goes out
          sh_q <= shift_in(sh_q, rx_smp_q);
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7)
            busy_q <= 1'b0;
        end
      end
    end
  end else begin
    // slave shifts on sck even in wait or stop
    if (ss_n_s) begin
      bit_q <= 3'h0;
      busy_q <= 1'b0;
    end else if (lp_enter && !busy_q) begin
      bit_q <= 3'h0; // partial idle byte dropped
    end else if (sck_rise) begin
      busy_q <= bit_q != 3'h7;
      bit_q <= bit_q + 3'h1;
      if (bit_q == 3'h7)
        // reload per byte: data reg or echo
        sh_q <= ctrl_q[`CTL_ECHO] ? {sh_q[6:0], rx_bit} : tx_q;
      else
        sh_q <= {sh_q[6:0], rx_bit};
    end
  end
end

// ------------------------------------------------
// completion, held byte and flags
// ------------------------------------------------
// a slave byte that ends in low power is parked here
// and posted on exit, but only if a transfer was
// running across the low power period; a wait that
// stays idle throughout leaves flag and data alone.
// the master never parks: it is frozen instead.
// a user expecting slave data in low power must
// leave low power before the byte can be read.
reg done_now; // flag set this cycle
reg [7:0] done_byte;
always @* begin
  done_now = 1'b0;
  done_byte = next_byte;
  if (done_p && !(low_pwr && !is_master)) begin
    done_now = 1'b1;
  end else if (lp_exit && held_q) begin
    done_now = lp_busy_q;
    done_byte = held_byte_q;
  end
end

always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    held_q <= 1'b0;
    held_byte_q <= 8'h00;
    lp_busy_q <= 1'b0;
    echo_q <= 8'h00;
  end else begin
    if (lp_enter)
      lp_busy_q <= busy_q;
    else if (low_pwr && busy_q)
      lp_busy_q <= 1'b1;
    else if (!low_pwr)
      lp_busy_q <= 1'b0;
    // slave byte done in low power waits for exit
    if (done_p && low_pwr && !is_master) begin
      held_q <= 1'b1;
      held_byte_q <= next_byte;
    end else if (lp_exit) begin
      held_q <= 1'b0;
    end
    if (done_p)
      echo_q <= next_byte;
  end
end

// ------------------------------------------------
// register file
// ------------------------------------------------
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    ctrl_q <= `CTL_RESET;
    stat_q <= 2'h0;
    mask_q <= 2'h0;
    data_q <= 8'h00;
    tx_q <= 8'h00;
    tx_pend_q <= 1'b0;
    mode_master_q <= 1'b0;
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h0;
  end else begin
    wb_ack_o <= wb_req;
    if (wb_req) begin
      if (wb_adr_i == `OFS_CTRL)
        wb_dat_o <= {24'h0, ctrl_q};
      else if (wb_adr_i == `OFS_STAT)
        wb_dat_o <= {29'h0, busy_q, stat_q};
      else if (wb_adr_i == `OFS_MASK)
        wb_dat_o <= {30'h0, mask_q};
      else if (wb_adr_i == `OFS_DATA)
        wb_dat_o <= {24'h0, data_q};
      else
        wb_dat_o <= 32'h0;
    end
    // writes
    if (wb_wr && wb_adr_i == `OFS_CTRL) begin
      ctrl_q <= wb_dat_i[7:0];
      mode_master_q <= wb_dat_i[`CTL_MASTER];
    end else if (modf_det) begin
      mode_master_q <= 1'b0; // fall back to slave
      ctrl_q[`CTL_MASTER] <= 1'b0;
    end
    if (wb_wr && wb_adr_i == `OFS_MASK)
      mask_q <= wb_dat_i[1:0];
    if (wb_wr && wb_adr_i == `OFS_DATA) begin
      tx_q <= wb_dat_i[7:0];
      tx_pend_q <= 1'b1;
    end else if (is_master && !busy_q && tx_pend_q && !low_pwr) begin
      tx_pend_q <= 1'b0;
    end
    // status: set wins over write-one clear
    if (wb_wr && wb_adr_i == `OFS_STAT)
      stat_q <= (stat_q & ~wb_dat_i[1:0]) | {modf_det, done_now};
    else
      stat_q <= stat_q | {modf_det, done_now};
    if (done_now)
      data_q <= done_byte;
  end
end

assign irq = |(stat_q & mask_q);

// ------------------------------------------------
// pin drivers
// ------------------------------------------------
// output enables are high while the block drives.
// in bidir mode only sck (as master) and the shared data pin may drive,
// the data pin only when the direction bit asks for output.
// a mode fault turns the master into a slave, so the
// shared pin moves from mosi to miso; a board that
// uses miso for something else must allow for this.
// the unused data pin is never driven.
// disabling the block releases every pin.
wire en = ctrl_q[`CTL_ENABLE];
wire oe_bidir = ctrl_q[`CTL_BIDIR_OE];
assign sck_o = sck_gen_q;
assign sck_oe = en & is_master;
assign mosi_o = sh_q[7];
assign miso_o = sh_q[7];
// master drives mosi; bidir uses oe bit
assign mosi_oe = en & is_master & (~bidir | oe_bidir);
// slave drives miso when selected
assign miso_oe = en & ~is_master & ~ss_n_s & (~bidir | oe_bidir);

endmodule

// ===== testbench/spi_lp_asserts.sv
`timescale 1ns/100ps
module spi_lp_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // power and pins
  input wire logic cpu_stop,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // one-cycle ack, one cycle after the request
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_dat_hold;
    !wb_ack_o |-> $stable(wb_dat_o);
  endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  // never both data pins driven
  property p_one_pin;
    !(mosi_oe && miso_oe);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("two pins");
  property p_sck_role;
    sck_oe |-> !miso_oe;
  endproperty
  a_sck_role: assert property (p_sck_role) else $error("role mix");
  property p_mosi_mst;
    mosi_oe |-> sck_oe;
  endproperty
  a_mosi_mst: assert property (p_mosi_mst) else $error("mosi as slave");
  // stop freezes the clock and holds back the flag
  property p_stop_sck;
    cpu_stop [*5] |-> $stable(sck_o);
  endproperty
  a_stop_sck: assert property (p_stop_sck) else $error("sck in stop");
  property p_stop_irq;
    cpu_stop [*5] |-> !$rose(irq);
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("irq in stop");
endmodule
bind spi_bidir_lowpower_ctrl spi_lp_chk u_chk (.mclk(mclk), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cpu_stop(cpu_stop), .sck_o(sck_o), .sck_oe(sck_oe),
  .mosi_oe(mosi_oe), .miso_oe(miso_oe), .irq(irq));

// ===== testbench/spi_ext_party.sv
`timescale 1ns/100ps
module spi_ext_party (
  // frame and pins
  input wire logic sel,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // byte to send, byte received
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  // released line shows the inverse of the last bit
  assign miso = sel ? sh[7] : ~sh[7];
  always @(posedge sel) sh = tx;
  always @(posedge sck) if (sel) rx = {rx[6:0], mosi};
  always @(negedge sck) if (sel) sh = {sh[6:0], ~sh[7]};
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps
`include "spi_lp_consts.vh"
module tb;
  logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, ack, irq;
  logic wt = 0, stp = 0, sck = 0, ssn = 1, mosi = 0, sel = 0, miso;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic [3:0] adr = 0;
  logic [31:0] wdat = 0, rdat, q[$];
  logic [7:0] ptx = 0, prx, b;
  wire sck_w = sck_oe ? sck_o : sck;
  wire mosi_w = mosi_oe ? mosi_o : mosi;
  wire miso_w = miso_oe ? miso_o : miso;
  int n_fail = 0, checked = 0, cyc_n = 0;
  always #5 mclk = ~mclk;
  spi_bidir_lowpower_ctrl dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .cpu_wait(wt),
    .cpu_stop(stp), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
    .ss_n_i(ssn), .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe), .irq(irq));
  spi_ext_party u_far (.sel(sel), .sck(sck_w), .mosi(mosi_w), .miso(miso),
    .tx(ptx), .rx(prx));
  task cmp(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task complete_run;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bus cycle held until ack is sampled
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    cyc <= 0; stb <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(0, a, 32'h0);
  endtask
  task wirq;
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge mclk);
  endtask
  // master byte start and finish
  task mgo(input logic [7:0] d);
    ptx <= 8'($urandom);
    @(posedge mclk);
    sel <= 1; // partner loads its byte after it settles
    bus(1, `OFS_DATA, {24'h0, d});
  endtask
  task mend(input logic [7:0] d, input logic [7:0] e);
    wirq;
    sel <= 0;
    cmp({24'h0, d}, {24'h0, prx});
    rd(`OFS_DATA, {24'h0, e});
    rd(`OFS_STAT, 32'h1);
    bus(1, `OFS_STAT, 32'h3);
  endtask
  // external master: one byte, 160 ns sck, data on fall
  task sxfer(input logic [7:0] m);
    for (int i = 7; i >= 0; i--) begin
      mosi <= m[i];
      repeat (8) @(posedge mclk);
      sck <= 1;
      repeat (8) @(posedge mclk);
      sck <= 0;
    end
  endtask
  // read results checked in order of issue
  always @(posedge mclk) if (ack === 1'b1 && cyc && !we && q.size() > 0)
    cmp(q.pop_front(), rdat);
  always @(posedge mclk) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_fail++;
      complete_run;
    end
  end
  initial begin
    b = $urandom(64775);
    repeat (12) @(posedge mclk);
    rst_n <= 1;
    repeat (3) @(posedge mclk);
    rd(`OFS_CTRL, 32'h0);
    rd(4'h2, 32'h0);
    bus(1, `OFS_MASK, 32'h1);
    b = $urandom;
    bus(1, `OFS_CTRL, 32'h03);
    mgo(b);
    mend(b, ptx);
    bus(1, `OFS_CTRL, 32'h0f);
    mgo(b);
    mend(b, b);
    // run normally, suspend in wait, freeze in stop
    for (int k = 0; k < 3; k++) begin
      b = $urandom;
      bus(1, `OFS_CTRL, k == 1 ? 32'h13 : 32'h03);
      mgo(b);
      wt <= k < 2; stp <= k == 2;
      repeat (200) @(posedge mclk);
      cmp(k == 0, 32'(irq));
      wt <= 0; stp <= 0;
      mend(b, ptx);
    end
    // wait entered and left while idle
    bus(1, `OFS_CTRL, 32'h11);
    wt <= 1;
    repeat (50) @(posedge mclk);
    wt <= 0;
    repeat (50) @(posedge mclk);
    rd(`OFS_STAT, 32'h0);
    // slave byte with wait entered mid-transfer
    ssn <= 0;
    b = $urandom;
    repeat (4) @(posedge mclk);
    fork
      sxfer(b);
      begin
        repeat (40) @(posedge mclk);
        wt <= 1;
      end
    join
    repeat (10) @(posedge mclk);
    cmp(32'h0, 32'(irq));
    wt <= 0;
    repeat (5) @(posedge mclk);
    rd(`OFS_DATA, {24'h0, b});
    rd(`OFS_STAT, 32'h1);
    bus(1, `OFS_STAT, 32'h3);
    // mode fault drops master
    ssn <= 0;
    bus(1, `OFS_CTRL, 32'h27);
    repeat (6) @(posedge mclk);
    rd(`OFS_CTRL, 32'h25);
    rd(`OFS_STAT, 32'h2);
    cmp(32'h0, 32'(mosi_oe));
    complete_run;
  end
endmodule
